// ### common/rtsr_pkg.sv
// Contract
// [RULE1] after reset the block converts again and again on its own, with no command from the master.
// [RULE2] a new conversion starts every 0.5 s on the fast variant and every 8 s on the slow one.
// [RULE3] a read at any time returns the last completed result, never a partial one.
// [RULE4] a rising edge of select resets the serial state and starts a fresh conversion.
// [RULE5] a falling edge of select aborts any conversion in progress.
// [RULE6] the master holds select high at least 320 ms after it rises so a conversion can finish.
// [RULE7] while select is low no conversion runs, but the last result can still be read.
// [RULE8] during reset the serial port is inactive and the result register holds zero degrees.
// [RULE9] a falling edge of select copies the current result into the output shift register.
// [RULE10] each new frame bit appears on a falling serial clock edge, most significant bit first.
// [RULE11] a frame spans 16 serial clock edges and carries bits 15 down to 0 in order.
// [RULE12] bits 1 and 0 of the frame leave the data output undriven.
// [RULE13] the temperature is a 13-bit two's-complement value with 0.0625 degree steps.
// [RULE14] frame bits 15 to 3 carry the temperature with sign in bit 15, and bit 2 is zero.
// [RULE15] while select is low the serial port stays enabled although the converter is idle.
// [RULE16] the data output is undriven while select is high and drives bit 15 soon after it falls.
// [RULE17] a finished conversion updates the readable result only when no frame is in progress.
package rtsr_pkg;
   localparam int TEMP_W = 13;
   localparam int FRAME_W = 16;
   localparam int FRAME_TEMP_LSB = 3;
   localparam int FRAME_HIZ_BITS = 2;
   localparam logic [TEMP_W-1:0] TEMP_RESET = 13'h0000;
   localparam logic [3:0] BIT_FIRST = 4'hf;
   localparam logic [3:0] BIT_LAST = 4'h0;
   localparam int CLK_HZ = 200_000_000;
   // conversion periods and conversion time in milliseconds
   localparam int FAST_PERIOD_MS = 500;
   localparam int SLOW_PERIOD_MS = 8000;
   localparam int CONV_TIME_MS = 320;
   localparam longint CYC_PER_MS = CLK_HZ / 1000;
   localparam longint FAST_PERIOD_CYC = FAST_PERIOD_MS * CYC_PER_MS;
   localparam longint SLOW_PERIOD_CYC = SLOW_PERIOD_MS * CYC_PER_MS;
   localparam longint CONV_TIME_CYC = CONV_TIME_MS * CYC_PER_MS;
   localparam int CNT_W = 32;
   typedef enum {CONV_IDLE, CONV_RUN, CONV_WAIT} rtsr_conv_t;
endpackage : rtsr_pkg

// ### common/rtsr_res_if.sv
`timescale 1ns/10ps
// result hand-off between converter and readout
interface rtsr_res_if;
   import rtsr_pkg::*;
   logic resValid;
   logic resReady;
   logic [TEMP_W-1:0] resData;
   modport src (output resValid, output resData, input resReady);
   modport snk (input resValid, input resData, output resReady);
endinterface : rtsr_res_if

// ### core/rtsr_fifo.sv
`timescale 1ns/10ps
module rtsr_fifo #(
   parameter int WIDTH = 13,
   parameter int DEPTH = 8
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic inValid,
   output logic inReady,
   input wire logic [WIDTH-1:0] inData,
   output logic outValid,
   input wire logic outReady,
   output logic [WIDTH-1:0] outData
);
   localparam int AW = $clog2(DEPTH);
   initial begin
      if (DEPTH < 2 || (1 << AW) != DEPTH || WIDTH < 1) begin
         $error("rtsr_fifo: depth must be a power of two, at least 2");
      end
   end
   logic [WIDTH-1:0] mem_r [DEPTH];
   logic [AW:0] wrPtr_r, wrPtr_nxt, rdPtr_r, rdPtr_nxt;
   logic wrEn, rdEn;
   always_comb begin
      inReady = (wrPtr_r - rdPtr_r) != (AW+1)'(DEPTH);
      outValid = wrPtr_r != rdPtr_r;
      outData = mem_r[rdPtr_r[AW-1:0]];
      wrEn = inValid && inReady;
      rdEn = outValid && outReady;
      wrPtr_nxt = wrPtr_r + (AW+1)'(wrEn);
      rdPtr_nxt = rdPtr_r + (AW+1)'(rdEn);
   end
   always_ff @(posedge clk) begin
      if (rst) begin
         wrPtr_r <= '0;
         rdPtr_r <= '0;
      end else begin
         wrPtr_r <= wrPtr_nxt;
         rdPtr_r <= rdPtr_nxt;
      end
      if (wrEn) begin
         mem_r[wrPtr_r[AW-1:0]] <= inData;
      end
   end
endmodule : rtsr_fifo

// ### core/rtsr_conv.sv
`timescale 1ns/10ps
// conversion sequencer: free-running periods, select-controlled start and abort
module rtsr_conv
   import rtsr_pkg::*;
#(
   parameter longint PERIOD_CYC = FAST_PERIOD_CYC,
   parameter longint CONV_CYC = CONV_TIME_CYC
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic selRise,
   input wire logic selFall,
   input wire logic selHigh,
   input wire logic [TEMP_W-1:0] adcSample,
   output logic converting,
   rtsr_res_if.src res
);
   initial begin
      if (CONV_CYC < 1 || PERIOD_CYC < CONV_CYC || PERIOD_CYC >= (64'h1 << CNT_W)) begin
         $error("rtsr_conv: conversion must fit inside the period");
      end
   end
   rtsr_conv_t state_r, state_nxt;
   logic [CNT_W-1:0] cnt_r, cnt_nxt;
   logic resValid_r, resValid_nxt;
   logic [TEMP_W-1:0] resData_r, resData_nxt;
   always_comb begin
      state_nxt = state_r;
      cnt_nxt = cnt_r + 32'h1;
      resValid_nxt = resValid_r && !res.resReady;
      resData_nxt = resData_r;
      case (state_r)
         CONV_RUN: begin
            if (cnt_r == CNT_W'(CONV_CYC - 1)) begin
               // result only leaves once the whole conversion has run
               resValid_nxt = 1'b1; // [RULE3]
               resData_nxt = adcSample; // [RULE13]
               state_nxt = CONV_WAIT;
            end
         end
         CONV_WAIT: begin
            if (cnt_r == CNT_W'(PERIOD_CYC - 1)) begin
               state_nxt = CONV_RUN; // [RULE1] [RULE2]
               cnt_nxt = '0;
            end
         end
         CONV_IDLE: begin
            cnt_nxt = '0; // [RULE7]
         end
         default: begin
            state_nxt = CONV_IDLE;
         end
      endcase
      if (selFall) begin
         state_nxt = CONV_IDLE; // [RULE5]
         cnt_nxt = '0;
      end else if (selRise) begin
         state_nxt = CONV_RUN; // [RULE4]
         cnt_nxt = '0;
      end else if (state_r == CONV_IDLE && selHigh) begin
         // after reset with select already high, start free-running
         state_nxt = CONV_RUN; // [RULE1]
      end
   end
   always_ff @(posedge clk) begin
      if (rst) begin
         state_r <= CONV_IDLE;
         cnt_r <= '0;
         resValid_r <= 1'b0;
         resData_r <= TEMP_RESET;
      end else begin
         state_r <= state_nxt;
         cnt_r <= cnt_nxt;
         resValid_r <= resValid_nxt;
         resData_r <= resData_nxt;
      end
   end
   assign res.resValid = resValid_r;
   assign res.resData = resData_r;
   assign converting = state_r == CONV_RUN;
endmodule : rtsr_conv

// ### core/rtsr_top.sv
`timescale 1ns/10ps
module rtsr_top
   import rtsr_pkg::*;
#(
   parameter longint PERIOD_CYC = FAST_PERIOD_CYC,
   parameter longint CONV_CYC = CONV_TIME_CYC,
   parameter int FIFO_DEPTH = 8
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic selN,
   input wire logic sck,
   input wire logic [TEMP_W-1:0] adcSample,
   output logic soOut,
   output logic soOe,
   output logic convBusy
);
   initial begin
      if (FIFO_DEPTH < 2 || FRAME_W != TEMP_W + FRAME_TEMP_LSB) begin
         $error("rtsr_top: bad frame or fifo shape");
      end
   end
   // ----------------------------------------
   // pin synchronisers
   // ----------------------------------------
   logic [1:0] selSync_r, sckSync_r;
   logic selDly_r, sckDly_r;
   logic selRise, selFall, sckFall;
   always_ff @(posedge clk) begin
      if (rst) begin
         selSync_r <= 2'h3;
         sckSync_r <= 2'h0;
         selDly_r <= 1'b1;
         sckDly_r <= 1'b0;
      end else begin
         selSync_r <= {selSync_r[0], selN};
         sckSync_r <= {sckSync_r[0], sck};
         selDly_r <= selSync_r[1];
         sckDly_r <= sckSync_r[1];
      end
   end
   assign selRise = selSync_r[1] && !selDly_r;
   assign selFall = !selSync_r[1] && selDly_r;
   assign sckFall = !sckSync_r[1] && sckDly_r;
   // ----------------------------------------
   // converter and result buffer
   // ----------------------------------------
   rtsr_res_if convRes ();
   rtsr_res_if bufRes ();
   logic busy;
   rtsr_conv #(.PERIOD_CYC(PERIOD_CYC), .CONV_CYC(CONV_CYC)) uConv (
      .clk(clk),
      .rst(rst),
      .selRise(selRise),
      .selFall(selFall),
      .selHigh(selSync_r[1]),
      .adcSample(adcSample),
      .converting(busy),
      .res(convRes.src)
   );
   rtsr_fifo #(.WIDTH(TEMP_W), .DEPTH(FIFO_DEPTH)) uFifo (
      .clk(clk),
      .rst(rst),
      .inValid(convRes.resValid),
      .inReady(convRes.resReady),
      .inData(convRes.resData),
      .outValid(bufRes.resValid),
      .outReady(bufRes.resReady),
      .outData(bufRes.resData)
   );
   // ----------------------------------------
   // readable result and serial frame
   // ----------------------------------------
   logic [TEMP_W-1:0] temp_r, temp_nxt;
   logic [FRAME_W-1:0] shift_r, shift_nxt;
   logic [3:0] bitIdx_r, bitIdx_nxt;
   logic inFrame_r, inFrame_nxt;
   logic soOut_r, soOut_nxt, soOe_r, soOe_nxt, busy_r;
   // a frame only drains the buffer when select is high, so no frame mixes results
   assign bufRes.resReady = selSync_r[1]; // [RULE17]
   always_comb begin
      temp_nxt = temp_r;
      shift_nxt = shift_r;
      bitIdx_nxt = bitIdx_r;
      inFrame_nxt = inFrame_r;
      soOut_nxt = soOut_r;
      soOe_nxt = soOe_r;
      if (bufRes.resValid && bufRes.resReady) begin
         temp_nxt = bufRes.resData; // [RULE3] [RULE17]
      end
      if (selFall) begin
         // snapshot: sign at 15, bit 2 zero, bits 1:0 later undriven
         shift_nxt = {temp_r, {FRAME_TEMP_LSB{1'b0}}}; // [RULE9] [RULE14]
         bitIdx_nxt = BIT_FIRST;
         inFrame_nxt = 1'b1;
         soOut_nxt = temp_r[TEMP_W-1]; // [RULE10] [RULE16]
         soOe_nxt = 1'b1; // [RULE15]
      end else if (!selSync_r[1]) begin
         if (inFrame_r && sckFall) begin
            if (bitIdx_r == BIT_LAST) begin
               inFrame_nxt = 1'b0; // [RULE11]
               soOe_nxt = 1'b0;
            end else begin
               bitIdx_nxt = bitIdx_r - 4'h1; // [RULE11]
               soOut_nxt = shift_r[bitIdx_r - 4'h1]; // [RULE10]
               soOe_nxt = (bitIdx_r - 4'h1) >= 4'(FRAME_HIZ_BITS); // [RULE12]
            end
         end
      end else begin
         // select high: port reset and released
         inFrame_nxt = 1'b0; // [RULE4]
         bitIdx_nxt = BIT_FIRST;
         soOe_nxt = 1'b0; // [RULE16]
         soOut_nxt = 1'b0;
      end
   end
   always_ff @(posedge clk) begin
      if (rst) begin
         temp_r <= TEMP_RESET; // [RULE8]
         shift_r <= '0;
         bitIdx_r <= BIT_FIRST;
         inFrame_r <= 1'b0;
         soOut_r <= 1'b0;
         soOe_r <= 1'b0; // [RULE8]
         busy_r <= 1'b0;
      end else begin
         temp_r <= temp_nxt;
         shift_r <= shift_nxt;
         bitIdx_r <= bitIdx_nxt;
         inFrame_r <= inFrame_nxt;
         soOut_r <= soOut_nxt;
         soOe_r <= soOe_nxt;
         busy_r <= busy;
      end
   end
   assign soOut = soOut_r;
   assign soOe = soOe_r;
   assign convBusy = busy_r;
endmodule : rtsr_top

// ### testbench/rtsr_top_monitor.sv
`timescale 1ns/10ps
module rtsr_top_monitor
   import rtsr_pkg::*;
#(
   parameter longint PERIOD_CYC = 200,
   parameter longint CONV_CYC = 50
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic selN,
   input wire logic sck,
   input wire logic [TEMP_W-1:0] adcSample,
   input wire logic soOut,
   input wire logic soOe,
   input wire logic convBusy
);
   logic [31:0] hiCnt_r;
   logic [31:0] gapCnt_r;
   logic [31:0] busyCnt_r;
   logic busyQ_r;
   // cycle counters let the long period checks avoid huge repetitions
   always_ff @(posedge clk) begin
      if (rst) begin
         hiCnt_r <= '0;
         gapCnt_r <= '0;
         busyCnt_r <= '0;
         busyQ_r <= 1'b0;
      end else begin
         hiCnt_r <= selN ? hiCnt_r + 32'h1 : '0;
         gapCnt_r <= (convBusy && !busyQ_r) ? 32'h1 : gapCnt_r + 32'h1;
         busyCnt_r <= convBusy ? busyCnt_r + 32'h1 : '0;
         busyQ_r <= convBusy;
      end
   end
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);
   sequence selDrop_s; $fell(selN); endsequence
   sequence drive_s; ##[3:6] soOe; endsequence
   sequence selRaise_s; $rose(selN); endsequence
   sequence start_s; ##[2:6] convBusy; endsequence
   chk_reset_quiet: assert property (disable iff (1'b0) rst |=> !soOe && !convBusy)
      else $error("outputs active during reset");
   chk_free_run: assert property ($fell(rst) && selN |-> ##[1:6] convBusy)
      else $error("no conversion after reset");
   chk_sel_start: assert property (selRaise_s |-> start_s)
      else $error("select rise started no conversion");
   chk_sel_drive: assert property (selDrop_s |-> drive_s)
      else $error("data not driven after select fall");
   chk_idle_quiet: assert property (!selN [*6] |-> !convBusy)
      else $error("conversion runs while select low");
   chk_undriven_high: assert property (selN [*5] |-> !soOe)
      else $error("data driven while select high");
   chk_tail_undriven: assert property ($fell(soOe) && !selN |=> !soOe [*8])
      else $error("data driven again in frame tail");
   chk_conv_period: assert property ($rose(convBusy) && hiCnt_r > PERIOD_CYC + 8
      |-> gapCnt_r == PERIOD_CYC)
      else $error("conversion period wrong");
   chk_conv_length: assert property ($fell(convBusy) && selN
      |-> busyCnt_r >= CONV_CYC - 1 && busyCnt_r <= CONV_CYC + 1)
      else $error("conversion length wrong");
endmodule : rtsr_top_monitor
bind rtsr_top rtsr_top_monitor #(.PERIOD_CYC(PERIOD_CYC), .CONV_CYC(CONV_CYC)) mon (
   .clk(clk), .rst(rst), .selN(selN), .sck(sck), .adcSample(adcSample),
   .soOut(soOut), .soOe(soOe), .convBusy(convBusy));

// ### testbench/rtsr_master_model.sv
`timescale 1ns/10ps
module rtsr_master_model (
   input wire logic clk,
   input wire logic soOut,
   input wire logic soOe,
   output logic selN,
   output logic sck
);
   // serial clock rests low between frames
   initial begin
      selN = 1'b1;
      sck = 1'b0;
   end
   // a shorter high time is legal but lets no conversion finish
   task automatic hold_high(input int n);
      selN = 1'b1;
      repeat (n) @(posedge clk);
   endtask : hold_high
   // bits are read just before the next fall, well after the output settles
   task automatic read_frame(input int nFalls, output logic [15:0] data, output logic [15:0] en);
      data = '0;
      en = '0;
      @(posedge clk);
      #1 selN = 1'b0;
      #100;
      for (int k = 15; k > 15 - nFalls; k--) begin
         sck = 1'b1;
         #22.3;
         data[k] = soOut;
         en[k] = soOe;
         #1.7;
         sck = 1'b0;
         #24;
      end
   endtask : read_frame
endmodule : rtsr_master_model

// ### testbench/rtsr_top_tb.sv
`timescale 1ns/10ps
module rtsr_top_tb
   import rtsr_pkg::*;
;
   localparam longint PER = 200;
   localparam longint CONV = 50;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic [TEMP_W-1:0] adcSample = 13'h0abc;
   logic [TEMP_W-1:0] last;
   logic [TEMP_W-1:0] v;
   logic [TEMP_W-1:0] corner [4] = '{13'h1000, 13'h1fff, 13'h0001, 13'h0190};
   logic selN, sck, soOut, soOe, convBusy;
   logic [15:0] got, oe;
   logic [31:0] seed = 32'h6425;
   int num_errors = 0;
   int total_checks = 0;
   int cycles = 0;
   always #2.5 clk = ~clk;
   rtsr_top #(.PERIOD_CYC(PER), .CONV_CYC(CONV), .FIFO_DEPTH(8)) dut (
      .clk(clk), .rst(rst), .selN(selN), .sck(sck), .adcSample(adcSample),
      .soOut(soOut), .soOe(soOe), .convBusy(convBusy));
   rtsr_master_model master (.clk(clk), .soOut(soOut), .soOe(soOe), .selN(selN), .sck(sck));
   function automatic logic [31:0] xs(input logic [31:0] s);
      s = s ^ (s << 13);
      s = s ^ (s >> 17);
      return s ^ (s << 5);
   endfunction : xs
   function automatic logic [15:0] exp_frame(input logic [TEMP_W-1:0] t);
      return {t, 3'b000};
   endfunction : exp_frame
   task automatic check(input logic [15:0] g, input logic [15:0] e);
      total_checks++;
      if (g !== e) begin
         num_errors++;
         $display("mismatch at %0t: got %h expected %h", $time, g, e);
      end
   endtask : check
   // bits 1 and 0 are masked: the line floats there
   task automatic read_expect(input logic [TEMP_W-1:0] t);
      master.read_frame(16, got, oe);
      check(got & 16'hfffc, exp_frame(t));
      check(oe, 16'hfffc);
      last = t;
   endtask : read_expect
   task automatic convert(input logic [TEMP_W-1:0] t, input int n);
      @(posedge clk);
      #1 adcSample = t;
      master.hold_high(n);
   endtask : convert
   task automatic complete_run();
      $display("checks %0d errors %0d", total_checks, num_errors);
      if (num_errors == 0 && total_checks > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask : complete_run
   always @(posedge clk) begin
      cycles++;
      if (cycles == 20000) begin
         num_errors++;
         $display("mismatch at %0t: timeout", $time);
         complete_run();
      end
   end
   initial begin
      repeat (6) @(posedge clk);
      #1 rst = 1'b0;
      read_expect(13'h0000);
      convert(13'h0fff, 500);
      read_expect(13'h0fff);
      for (int i = 0; i < 10; i++) begin
         seed = xs(seed);
         v = (i < 4) ? corner[i] : seed[TEMP_W-1:0];
         convert(v, 80);
         read_expect(v);
      end
      // a conversion cut short leaves the previous result readable
      convert(~last, 20);
      read_expect(last);
      // a broken frame must not shift the next one; a short high pulse opens it
      convert(last, 4);
      master.read_frame(5, got, oe);
      convert(13'h1555, 80);
      read_expect(13'h1555);
      complete_run();
   end
endmodule : rtsr_top_tb
